//--- verilog/reset_seq_cfg.svh
// Constants of the reset pin sequencer: counts, widths and reset values.
// Assumes one clock at the system clock output rate.
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// Drive, release and filter intervals in system clock output cycles.
`define DRIVE_CYC 10'd512
`define RELEASE_CYC 10'd10
`define EXT_MIN_CYC 4'd4
`define BUS_TMO_CYC 10'd64
`define MSTR_HOLD_CYC 3'd4
`define CNT_W 10
`define DATA_W 16

// Reset cause bit positions and their power-up value.
`define CAUSE_EXT 0
`define CAUSE_POWER 1
`define CAUSE_INT 2
`define CAUSE_RST 3'h2

`endif

//--- verilog/reset_seq_pkg.sv
// Types shared by the reset pin sequencer and its pin synchroniser.
// Assumes reset_seq_cfg.svh for widths.
`include "reset_seq_cfg.svh"

package reset_seq_pkg;

  typedef enum logic [2:0] {
    ST_POWER, ST_RUN, ST_ARM, ST_EXT_WAIT, ST_DRIVE, ST_RELEASE, ST_CAPTURE
  } seq_e;

  // Pins sampled from outside the clock domain.
  typedef struct packed {
    logic reset_pin;
    logic pll_lock;
    logic clock_source_select;
    logic [`DATA_W-1:0] data;
  } pin_in_s;

  // Pin function controls handed to the port and module logic.
  typedef struct packed {
    logic port_dir_clear;
    logic periph_fn_disable;
    logic data_mode_input;
    logic outputs_live;
    logic timer_pwm_output;
    logic serial_rx_keep;
  } pin_cfg_s;

  typedef struct packed {
    seq_e state;
    logic [`CNT_W-1:0] cnt;
    logic [3:0] low_cnt;
    logic [2:0] mst_cnt;
    logic reset_pin_oe_n;
    logic master_reset_line;
    logic external_reset_line;
    logic module_reset;
    logic boot_memory_select_n;
    logic chip_select_hold;
    logic exc_start;
    logic clock_source_select;
    logic [`DATA_W-1:0] mode;
    logic [2:0] cause;
    logic [2:0] pend_cause;
    pin_cfg_s cfg;
  } seq_state_s;

endpackage : reset_seq_pkg

//--- verilog/reset_pin_sync.sv
// Two-flop synchroniser for all pins read by the reset sequencer.
// Assumes inputs are asynchronous to REF_CLK.
`timescale 1ns/1ns

module reset_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire reset_seq_pkg::pin_in_s pin_async,
  output reset_seq_pkg::pin_in_s pin_sync
);

  typedef struct packed {
    reset_seq_pkg::pin_in_s meta;
    reset_seq_pkg::pin_in_s stable;
  } sync_state_s;

  sync_state_s cur;
  sync_state_s next_cur;

  // Pins idle high through their pull-ups, so reset to high; lock resets low so that
  // a stale high cannot start the 512-cycle drive count (ST_DRIVE) before the synthesiser locks.
  always_comb begin
    next_cur.meta = pin_async;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '1;
      cur.meta.pll_lock <= 1'b0;
      cur.stable.pll_lock <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pin_sync = cur.stable;

endmodule : reset_pin_sync

//--- verilog/reset_pin_sequencer.sv
// Reset pin sequencer: drives and tests the open-drain reset pin, holds
// master and external reset lines, captures mode pins and sets pin functions.
// Assumes REF_CLK is the system clock output and RSTN is the power-on reset.
`timescale 1ns/1ns
`include "reset_seq_cfg.svh"

module reset_pin_sequencer (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Reset pin, open drain
  input wire logic RESET_PIN_IN,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE_N,
  // Clock synthesiser and mode pins
  input wire logic PLL_LOCK,
  input wire logic CLOCK_SOURCE_SELECT_IN,
  input wire logic [`DATA_W-1:0] DATA_IN,
  // Internal requests
  input wire logic INT_RESET_REQ,
  input wire logic BUS_IDLE,
  // Reset lines
  output logic MASTER_RESET_LINE,
  output logic EXTERNAL_RESET_LINE,
  output logic MODULE_RESET,
  // Pin functions and selects
  output logic BOOT_MEMORY_SELECT_N,
  output logic CHIP_SELECT_HOLD,
  output reset_seq_pkg::pin_cfg_s PIN_CFG,
  // Captured mode and status
  output logic [`DATA_W-1:0] MODE_SELECT,
  output logic CLOCK_SOURCE_SELECT,
  output logic [2:0] RESET_CAUSE,
  output logic EXC_START
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  reset_seq_pkg::pin_in_s pin_async;
  reset_seq_pkg::pin_in_s pin_s;

  assign pin_async = '{reset_pin: RESET_PIN_IN, pll_lock: PLL_LOCK,
                       clock_source_select: CLOCK_SOURCE_SELECT_IN, data: DATA_IN};

  reset_pin_sync u_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .pin_async(pin_async),
    .pin_sync(pin_s)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  reset_seq_pkg::seq_state_s cur;
  reset_seq_pkg::seq_state_s next_cur;
  logic in_reset;

  always_comb begin
    next_cur = cur;
    next_cur.exc_start = 1'b0;
    next_cur.cnt = cur.cnt + 10'h001;
    case (cur.state)
      reset_seq_pkg::ST_POWER: begin
        next_cur.cnt = '0;
        if (pin_s.pll_lock) begin
          next_cur.state = reset_seq_pkg::ST_DRIVE;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        next_cur.cnt = '0;
        if (INT_RESET_REQ) begin
          next_cur.state = reset_seq_pkg::ST_DRIVE;
          next_cur.pend_cause[`CAUSE_INT] = 1'b1;
        end else if (!pin_s.reset_pin) begin
          next_cur.low_cnt = cur.low_cnt + 4'h1;
          if (cur.low_cnt == `EXT_MIN_CYC - 4'h1) begin
            next_cur.state = reset_seq_pkg::ST_ARM;
            next_cur.pend_cause[`CAUSE_EXT] = 1'b1;
          end
        end else begin
          next_cur.low_cnt = '0;
        end
      end
      reset_seq_pkg::ST_ARM: begin
        if (BUS_IDLE || cur.cnt == `BUS_TMO_CYC - 10'h001) begin
          next_cur.state = reset_seq_pkg::ST_EXT_WAIT;
          next_cur.cnt = '0;
        end
      end
      reset_seq_pkg::ST_EXT_WAIT: begin
        next_cur.cnt = '0;
        if (pin_s.reset_pin) begin
          next_cur.state = reset_seq_pkg::ST_DRIVE;
        end
      end
      reset_seq_pkg::ST_DRIVE: begin
        if (cur.cnt >= `DRIVE_CYC - 10'h001) begin
          next_cur.cnt = cur.cnt;
          if (!INT_RESET_REQ) begin
            next_cur.state = reset_seq_pkg::ST_RELEASE;
            next_cur.cnt = '0;
          end
        end
      end
      reset_seq_pkg::ST_RELEASE: begin
        if (cur.cnt == `RELEASE_CYC - 10'h001) begin
          next_cur.cnt = '0;
          if (pin_s.reset_pin) begin
            next_cur.state = reset_seq_pkg::ST_CAPTURE;
          end else begin
            next_cur.state = reset_seq_pkg::ST_DRIVE;
          end
        end
      end
      reset_seq_pkg::ST_CAPTURE: begin
        // Mode pins are latched in the same cycle that exception processing is flagged.
        next_cur.mode = pin_s.data;
        next_cur.clock_source_select = pin_s.clock_source_select;
        next_cur.cause = cur.pend_cause;
        next_cur.pend_cause = '0;
        next_cur.exc_start = 1'b1;
        next_cur.low_cnt = '0;
        next_cur.cnt = '0;
        next_cur.state = reset_seq_pkg::ST_RUN;
      end
      default: begin
        next_cur.state = reset_seq_pkg::ST_POWER;
      end
    endcase

    // Outputs other than MODULE_RESET follow the next state so they line up with the phases.
    in_reset = !(next_cur.state == reset_seq_pkg::ST_RUN ||
                 next_cur.state == reset_seq_pkg::ST_ARM);
    next_cur.reset_pin_oe_n = !(next_cur.state == reset_seq_pkg::ST_DRIVE ||
                                next_cur.state == reset_seq_pkg::ST_POWER);
    next_cur.master_reset_line = in_reset && next_cur.state != reset_seq_pkg::ST_CAPTURE;
    next_cur.external_reset_line = next_cur.master_reset_line;
    next_cur.mst_cnt = cur.master_reset_line ?
                       ((cur.mst_cnt == `MSTR_HOLD_CYC) ? cur.mst_cnt : cur.mst_cnt + 3'h1) : '0;
    next_cur.module_reset = cur.master_reset_line &&
                            (cur.mst_cnt >= `MSTR_HOLD_CYC - 3'h1);
    next_cur.chip_select_hold = next_cur.master_reset_line;
    next_cur.boot_memory_select_n = next_cur.master_reset_line;
    next_cur.cfg.port_dir_clear = next_cur.master_reset_line;
    next_cur.cfg.periph_fn_disable = next_cur.master_reset_line;
    next_cur.cfg.data_mode_input = next_cur.master_reset_line;
    next_cur.cfg.outputs_live = !next_cur.master_reset_line;
    next_cur.cfg.timer_pwm_output = 1'b1;
    next_cur.cfg.serial_rx_keep = 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur <= '0;
      cur.state <= reset_seq_pkg::ST_POWER;
      cur.reset_pin_oe_n <= 1'b0;
      cur.master_reset_line <= 1'b1;
      cur.external_reset_line <= 1'b1;
      cur.boot_memory_select_n <= 1'b1;
      cur.chip_select_hold <= 1'b1;
      cur.pend_cause <= `CAUSE_RST;
      cur.cfg <= 6'h3b;
    end else begin
      cur <= next_cur;
    end
  end

  assign RESET_PIN_OUT = 1'b0;
  assign RESET_PIN_OE_N = cur.reset_pin_oe_n;
  assign MASTER_RESET_LINE = cur.master_reset_line;
  assign EXTERNAL_RESET_LINE = cur.external_reset_line;
  assign MODULE_RESET = cur.module_reset;
  assign BOOT_MEMORY_SELECT_N = cur.boot_memory_select_n;
  assign CHIP_SELECT_HOLD = cur.chip_select_hold;
  assign PIN_CFG = cur.cfg;
  assign MODE_SELECT = cur.mode;
  assign CLOCK_SOURCE_SELECT = cur.clock_source_select;
  assign RESET_CAUSE = cur.cause;
  assign EXC_START = cur.exc_start;

  // ****************************************
  // Assertions
  // ****************************************
  logic [`CNT_W-1:0] drv_len;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      drv_len <= '0;
    end else if (RESET_PIN_OE_N) begin
      drv_len <= '0;
    end else if (drv_len != '1) begin
      drv_len <= drv_len + 10'h001;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  property p_drive_len;
    $rose(RESET_PIN_OE_N) |-> drv_len >= `DRIVE_CYC;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("reset pin driven too briefly");

  property p_int_hold;
    (cur.state == reset_seq_pkg::ST_DRIVE && INT_RESET_REQ) |=> !RESET_PIN_OE_N;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("drive ended during internal request");

  property p_release_ten;
    $rose(RESET_PIN_OE_N) && MASTER_RESET_LINE |-> RESET_PIN_OE_N [*8] ##1 RESET_PIN_OE_N ##1
      RESET_PIN_OE_N ##1 (!RESET_PIN_OE_N || !MASTER_RESET_LINE);
  endproperty
  a_release_ten: assert property (p_release_ten) else $error("release window not ten cycles");

  property p_retry;
    (cur.state == reset_seq_pkg::ST_RELEASE && cur.cnt == `RELEASE_CYC - 10'h001 &&
     !pin_s.reset_pin) |=> !RESET_PIN_OE_N;
  endproperty
  a_retry: assert property (p_retry) else $error("low sample did not restart drive");

  property p_pll_hold;
    !pin_s.pll_lock && cur.state == reset_seq_pkg::ST_POWER |=> EXTERNAL_RESET_LINE;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("external reset left before lock");

  property p_module_after_four;
    $rose(MODULE_RESET) |-> $past(MASTER_RESET_LINE, 4) && MASTER_RESET_LINE;
  endproperty
  a_module_after_four: assert property (p_module_after_four) else $error("module reset early");

  property p_selects_in_reset;
    MASTER_RESET_LINE |-> CHIP_SELECT_HOLD && BOOT_MEMORY_SELECT_N && PIN_CFG.data_mode_input;
  endproperty
  a_selects_in_reset: assert property (p_selects_in_reset) else $error("selects active in reset");

  property p_release_order;
    $fell(MASTER_RESET_LINE) |-> !BOOT_MEMORY_SELECT_N && !EXC_START ##1 EXC_START;
  endproperty
  a_release_order: assert property (p_release_order) else $error("release order broken");

  property p_cause_set;
    $fell(MASTER_RESET_LINE) |=> RESET_CAUSE != 3'h0;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("no reset cause recorded");

  property p_pins_after;
    $fell(MASTER_RESET_LINE) |-> PIN_CFG.outputs_live && !PIN_CFG.port_dir_clear;
  endproperty
  a_pins_after: assert property (p_pins_after) else $error("pins not live after release");

  c_retry: cover property (cur.state == reset_seq_pkg::ST_RELEASE ##1
                           cur.state == reset_seq_pkg::ST_DRIVE);
  c_external: cover property (cur.state == reset_seq_pkg::ST_EXT_WAIT ##[1:50] !RESET_PIN_OE_N);
  c_internal: cover property ($fell(MASTER_RESET_LINE) ##1 RESET_CAUSE[`CAUSE_INT]);

endmodule : reset_pin_sequencer

//--- test/reset_board_net.sv
// Board model of the open-drain reset line with its pull-up.
// Assumes the sequencer drives low only while its enable is low.
`timescale 1ns/1ns

module reset_board_net (
  // Device side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Board sources
  input wire logic ext_pull,
  input wire logic stuck_low,
  // Resolved wire
  output logic pin_level
);
  // The pull-up wins only when no party pulls the line low.
  assign pin_level = !((!pin_oe_n && !pin_out) || ext_pull || stuck_low);
endmodule : reset_board_net

//--- test/reset_pin_sequencer_tb.sv
// Self-checking bench of the reset pin sequencer.
// Assumes the board model and a 100 MHz system clock output.
`timescale 1ns/1ns
`include "reset_seq_cfg.svh"

module reset_pin_sequencer_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic pll_lock = 1'b0;
  logic int_req = 1'b0;
  logic bus_idle = 1'b1;
  logic ext_pull = 1'b0;
  logic stuck = 1'b0;
  logic clk_sel_in = 1'b1;
  logic [`DATA_W-1:0] data_in = 16'h5a3c;
  logic pin_level, pin_out, oe_n, master, ext_line, module_rst, boot_n, cs_hold, exc, clk_sel;
  reset_seq_pkg::pin_cfg_s pin_cfg;
  logic [`DATA_W-1:0] mode;
  logic [2:0] cause;
  int bad_count = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  reset_board_net reset_board_net_i (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_pull(ext_pull),
    .stuck_low(stuck), .pin_level(pin_level));

  reset_pin_sequencer reset_pin_sequencer_i (.REF_CLK(ref_clk), .RSTN(rstn),
    .RESET_PIN_IN(pin_level), .RESET_PIN_OUT(pin_out), .RESET_PIN_OE_N(oe_n),
    .PLL_LOCK(pll_lock), .CLOCK_SOURCE_SELECT_IN(clk_sel_in), .DATA_IN(data_in),
    .INT_RESET_REQ(int_req), .BUS_IDLE(bus_idle), .MASTER_RESET_LINE(master),
    .EXTERNAL_RESET_LINE(ext_line), .MODULE_RESET(module_rst),
    .BOOT_MEMORY_SELECT_N(boot_n), .CHIP_SELECT_HOLD(cs_hold), .PIN_CFG(pin_cfg),
    .MODE_SELECT(mode), .CLOCK_SOURCE_SELECT(clk_sel), .RESET_CAUSE(cause), .EXC_START(exc));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    bad_count++;
    $display("mismatch at %0t: got %h expected %h", $time, 16'h0, 16'h1);
    final_report();
  endtask : hang

  // Walks drive and release phases until the sequence ends, then checks the release.
  task automatic seq(input int lo, input int hi, input int drives, input logic [2:0] cse);
    int n;
    int r;
    int d;
    d = 0;
    n = 0;
    while (oe_n !== 1'b0 && n < 2000) begin n++; step(); end
    if (n >= 2000) hang();
    do begin
      n = 0;
      while (oe_n === 1'b0 && n < 2000) begin n++; step(); end
      if (n >= 2000) hang();
      if (d == 0) chk(16'(n >= lo && n <= hi), 16'h1);
      else chk(16'(n), 16'd512);
      r = 0;
      while (oe_n === 1'b1 && master === 1'b1 && r < 20) begin r++; step(); end
      chk(16'(r), 16'd10);
      d++;
    end while (master === 1'b1 && d < 8);
    chk(16'(d), 16'(drives));
    chk({15'h0, boot_n}, 16'h0);
    chk({15'h0, cs_hold}, 16'h0);
    step();
    chk({15'h0, exc}, 16'h1);
    chk({13'h0, cause}, {13'h0, cse});
    chk(mode, data_in);
    chk({15'h0, clk_sel}, {15'h0, clk_sel_in});
    chk({10'h0, pin_cfg}, 16'h07);
    step();
    chk({15'h0, exc}, 16'h0);
    data_in = 16'hffff;
  endtask : seq

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power();
    repeat (3) step();
    chk({13'h0, module_rst, boot_n, cs_hold}, 16'h3);
    chk({10'h0, pin_cfg}, 16'h3b);
    chk({14'h0, master, ext_line}, 16'h3);
    repeat (20) step();
    chk({15'h0, oe_n}, 16'h0);
    chk({15'h0, module_rst}, 16'h1);
    pll_lock = 1'b1;
    seq(512, 516, 1, 3'h2);
    $display("test power-up done");
  endtask : t_power

  task automatic t_internal();
    data_in = 16'h00ff;
    clk_sel_in = 1'b0;
    int_req = 1'b1;
    step();
    chk({12'h0, oe_n, master, boot_n, cs_hold}, 16'h7);
    int_req = 1'b0;
    seq(512, 512, 1, 3'h4);
    $display("test internal done");
  endtask : t_internal

  task automatic t_extended();
    int_req = 1'b1;
    repeat (600) step();
    chk({15'h0, oe_n}, 16'h0);
    int_req = 1'b0;
    seq(1, 1, 1, 3'h4);
    $display("test extended done");
  endtask : t_extended

  task automatic t_short();
    int n;
    n = 0;
    ext_pull = 1'b1;
    repeat (2) step();
    ext_pull = 1'b0;
    repeat (60) begin step(); if (oe_n !== 1'b1) n++; end
    chk(16'(n), 16'h0);
    $display("test short pulse done");
  endtask : t_short

  task automatic t_external();
    int n;
    n = 0;
    bus_idle = 1'b0;
    ext_pull = 1'b1;
    repeat (20) begin step(); if (oe_n !== 1'b1) n++; end
    chk({15'h0, master}, 16'h0);
    bus_idle = 1'b1;
    step();
    chk({15'h0, master}, 16'h1);
    repeat (20) begin step(); if (oe_n !== 1'b1) n++; end
    chk(16'(n), 16'h0);
    ext_pull = 1'b0;
    seq(512, 512, 1, 3'h1);
    $display("test external done");
  endtask : t_external

  task automatic t_stuck();
    stuck = 1'b1;
    int_req = 1'b1;
    step();
    int_req = 1'b0;
    fork
      seq(512, 512, 2, 3'h4);
      begin repeat (700) step(); stuck = 1'b0; end
    join
    $display("test stuck line done");
  endtask : t_stuck

  initial begin
    repeat (2) step();
    rstn = 1'b1;
    t_power();
    t_internal();
    t_extended();
    t_short();
    t_external();
    t_stuck();
    final_report();
  end
endmodule : reset_pin_sequencer_tb
